// *** hdl/etp_conditioner.sv ***
`timescale 1ns/1ns
module etp_conditioner
    import etp_pkg::*;
#(
    parameter int unsigned ACC_CYCLES = ACC_CYC
)
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit backplane
    input  wire logic        transmit_backplane_clock,
    input  wire logic        transmit_common_frame_pulse,
    input  wire logic        transmit_serial_data_in,
    input  wire logic        transmit_signaling_in,
    input  wire logic        receive_payload_in,
    output logic             tx_data_out,
    output logic             tx_sig_out,
    // Pattern generator and detector
    input  wire logic        pattern_gen_bit,
    output logic             pattern_gen_req,
    output logic             pattern_det_bit,
    output logic             pattern_det_valid
);
    localparam int CW = $clog2(ACC_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(ACC_CYCLES - 1);

    logic [7:0]    mem_ff [IND_WORDS];
    logic [7:0]    data_buf_ff;
    logic [7:0]    ac_ff;
    logic          en_ff;
    logic [1:0]    own_ff;
    logic [CW-1:0] cnt_ff;
    etp_state_type st_ff;
    logic          req_ff;
    logic [6:0]    hs_idx_ff;
    logic [7:0]    hs_data_ff;
    logic          ack_s1_ff;
    logic          ack_s2_ff;
    logic          ack_l_ff;
    logic          pready_ff;
    logic          pslverr_ff;
    logic [31:0]   prdata_ff;

    // Bus decode
    wire        acc      = psel & penable & pready_ff;
    wire        first    = psel & penable & ~pready_ff;
    wire [9:0]  ridx     = paddr[11:2];
    wire        hit_cfg  = ridx == IDX_CFG;
    wire        hit_stat = ridx == IDX_STAT;
    wire        hit_ac   = ridx == IDX_AC;
    wire        hit_data = ridx == IDX_DATA;
    wire        hit_own  = ridx == IDX_OWN;
    wire        mapped   = hit_cfg | hit_stat | hit_ac | hit_data | hit_own;
    wire        busy     = st_ff != ST_IDLE;
    wire        start    = acc & pwrite & hit_ac & ~busy;
    wire        new_rw   = pwdata[AC_RW_BIT];
    wire [6:0]  new_a    = pwdata[6:0];
    wire [6:0]  new_idx  = new_a - IND_CTL_BASE;
    wire [6:0]  cur_idx  = ac_ff[6:0] - IND_CTL_BASE;
    wire        cur_ok   = ind_ok(ac_ff[6:0]);
    wire        acked    = ack_s2_ff == req_ff;
    wire        done     = (st_ff == ST_RUN) && (cnt_ff == CNT_LAST);
    wire [31:0] rd_mux   = hit_cfg  ? {31'h0, en_ff} :
                           hit_stat ? {24'h0, busy, 7'h00} :
                           hit_ac   ? {24'h0, ac_ff} :
                           hit_data ? {24'h0, data_buf_ff} :
                           hit_own  ? {30'h0, own_ff} : 32'h0;

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // Bus answer one cycle into access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end
        else
        begin
            pready_ff  <= first;
            pslverr_ff <= first & ~mapped;
            if (first & ~pwrite)
                prdata_ff <= rd_mux;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_ff  <= RST_EN;
            own_ff <= RST_OWN;
            ac_ff  <= RST_AC;
        end
        else
        begin
            if (acc & pwrite & hit_cfg)
                en_ff <= pwdata[CFG_EN_BIT];
            if (acc & pwrite & hit_own)
                own_ff <= pwdata[1:0];
            if (start)
                ac_ff <= pwdata[7:0];
        end
    end

    // Data buffer, loaded by software or read completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_buf_ff <= RST_DATA;
        else if (done & ac_ff[AC_RW_BIT])
            data_buf_ff <= cur_ok ? mem_ff[cur_idx] : 8'h00;
        else if (acc & pwrite & hit_data)
            data_buf_ff <= pwdata[7:0];
    end

    // Indirect sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff  <= ST_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            case (st_ff)
                ST_IDLE:
                    if (start)
                    begin
                        st_ff  <= ST_RUN;
                        cnt_ff <= '0;
                    end
                ST_RUN:
                    if (done)
                        st_ff <= acked ? ST_IDLE : ST_SYNC;
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                ST_SYNC:
                    if (acked)
                        st_ff <= ST_IDLE;
                default:
                    st_ff <= ST_IDLE;
            endcase
        end
    end

    // Indirect write and hand-off to link side
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < IND_WORDS; i++)
                mem_ff[i] <= 8'h00;
            req_ff     <= 1'b0;
            hs_idx_ff  <= 7'h00;
            hs_data_ff <= 8'h00;
            ack_s1_ff  <= 1'b0;
            ack_s2_ff  <= 1'b0;
        end
        else
        begin
            ack_s1_ff <= ack_l_ff;
            ack_s2_ff <= ack_s1_ff;
            if (start & ~new_rw & ind_ok(new_a))
            begin
                mem_ff[new_idx] <= data_buf_ff;
                hs_idx_ff       <= new_idx;
                hs_data_ff      <= data_buf_ff;
                req_ff          <= ~req_ff;
            end
        end
    end

    // Link domain reset and crossings
    logic       lrst_m_ff;
    logic       lrst_n_ff;
    logic [2:0] cfg_s1_ff;
    logic [2:0] cfg_s2_ff;
    logic       req_s1_ff;
    logic       req_s2_ff;
    logic [7:0] shd_ff [IND_WORDS];

    always_ff @(posedge transmit_backplane_clock or negedge presetn)
    begin
        if (!presetn)
        begin
            lrst_m_ff <= 1'b0;
            lrst_n_ff <= 1'b0;
        end
        else
        begin
            lrst_m_ff <= 1'b1;
            lrst_n_ff <= lrst_m_ff;
        end
    end

    always_ff @(posedge transmit_backplane_clock or negedge lrst_n_ff)
    begin
        if (!lrst_n_ff)
        begin
            for (int i = 0; i < IND_WORDS; i++)
                shd_ff[i] <= 8'h00;
            cfg_s1_ff <= 3'h0;
            cfg_s2_ff <= 3'h0;
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            ack_l_ff  <= 1'b0;
        end
        else
        begin
            cfg_s1_ff <= {own_ff, en_ff};
            cfg_s2_ff <= cfg_s1_ff;
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
            if (req_s2_ff != ack_l_ff)
            begin
                shd_ff[hs_idx_ff] <= hs_data_ff;
                ack_l_ff          <= req_s2_ff;
            end
        end
    end

    // Slot timing and per-slot settings
    logic [7:0] pos_ff;
    logic [2:0] mw_idx_ff;
    logic       in_ff;
    logic       rx_ff;
    logic       sig_in_ff;
    logic [7:0] ctl_ff;
    logic [7:0] idle_ff;
    logic [7:0] sig_ff;
    logic [2:0] cur_cfg_ff;
    logic       tx_data_ff;
    logic       tx_sig_ff;
    logic       det_bit_ff;
    logic       det_val_ff;

    wire [7:0] nxt_pos = transmit_common_frame_pulse ? 8'h00 : pos_ff + 8'h01;
    wire [6:0] nslot   = {2'h0, nxt_pos[7:3]};
    wire       slot_go = nxt_pos[2:0] == 3'h0;
    wire [2:0] k       = ~pos_ff[2:0];
    wire       en_l    = cur_cfg_ff[0];
    wire       cas_l   = cur_cfg_ff[1 + OWN_CAS_BIT];
    wire       dir_l   = cur_cfg_ff[1 + OWN_DIR_BIT];
    wire       do_ext  = en_l & ctl_ff[CTL_TEST] & dir_l;
    wire       do_gen  = en_l & ctl_ff[CTL_TEST] & ~dir_l;
    wire       do_lp   = en_l & ctl_ff[CTL_LOOP];
    wire       do_mw   = en_l & ctl_ff[CTL_SUBSTITUTE_SELECT] & ctl_ff[CTL_DS0];
    wire       do_idle = en_l & ctl_ff[CTL_SUBSTITUTE_SELECT] & ~ctl_ff[CTL_DS0];
    wire       inv_bit = en_l & ~ctl_ff[CTL_SUBSTITUTE_SELECT] &
                         ((ctl_ff[CTL_DS1] & ~k[0]) | (ctl_ff[CTL_DS0] & k[0]));
    wire [7:0] mw_val  = mw_byte(~ctl_ff[CTL_DS1], mw_idx_ff);
    wire       use_gen = do_gen & ~do_ext & ~do_lp & ~do_mw;
    wire       sig_own = en_l & cas_l & sig_ff[SIG_SRC_BIT] & pos_ff[2];
    wire       nxt_tx  = do_ext  ? in_ff :
                         do_lp   ? rx_ff :
                         do_mw   ? mw_val[k] :
                         use_gen ? pattern_gen_bit :
                         do_idle ? idle_ff[k] :
                         in_ff ^ inv_bit;

    assign pattern_gen_req   = use_gen;
    assign tx_data_out       = tx_data_ff;
    assign tx_sig_out        = tx_sig_ff;
    assign pattern_det_bit   = det_bit_ff;
    assign pattern_det_valid = det_val_ff;

    always_ff @(posedge transmit_backplane_clock or negedge lrst_n_ff)
    begin
        if (!lrst_n_ff)
        begin
            pos_ff     <= 8'hFF;
            mw_idx_ff  <= 3'h0;
            in_ff      <= 1'b0;
            rx_ff      <= 1'b0;
            sig_in_ff  <= 1'b0;
            ctl_ff     <= 8'h00;
            idle_ff    <= 8'h00;
            sig_ff     <= 8'h00;
            cur_cfg_ff <= 3'h0;
        end
        else
        begin
            pos_ff    <= nxt_pos;
            in_ff     <= transmit_serial_data_in;
            rx_ff     <= receive_payload_in;
            sig_in_ff <= transmit_signaling_in;
            if (transmit_common_frame_pulse)
                mw_idx_ff <= mw_idx_ff + 3'h1;
            if (slot_go)
            begin
                ctl_ff     <= shd_ff[nslot];
                idle_ff    <= shd_ff[nslot + IND_IDLE_OFS];
                sig_ff     <= shd_ff[nslot + IND_SIG_OFS];
                cur_cfg_ff <= cfg_s2_ff;
            end
        end
    end

    // Output stage
    always_ff @(posedge transmit_backplane_clock or negedge lrst_n_ff)
    begin
        if (!lrst_n_ff)
        begin
            tx_data_ff <= 1'b0;
            tx_sig_ff  <= 1'b0;
            det_bit_ff <= 1'b0;
            det_val_ff <= 1'b0;
        end
        else
        begin
            tx_data_ff <= nxt_tx;
            tx_sig_ff  <= sig_own ? sig_ff[k] : sig_in_ff;
            det_bit_ff <= in_ff;
            det_val_ff <= do_ext;
        end
    end

    // Checks, bus domain
    sequence s_busy8;
        busy [*8];
    endsequence

    a_busy_after_start: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> s_busy8) else $error("busy not held after start");
    a_busy_min_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(busy) |-> $past(busy, 13)) else $error("busy shorter than access");
    a_read_loads: assert property (@(posedge pclk) disable iff (!presetn)
        done & ac_ff[AC_RW_BIT] & cur_ok |=> data_buf_ff == mem_ff[cur_idx])
        else $error("read data not loaded");
    a_write_stores: assert property (@(posedge pclk) disable iff (!presetn)
        start & ~new_rw & ind_ok(new_a) |=> mem_ff[$past(new_idx)] == $past(data_buf_ff))
        else $error("indirect write lost");
    a_busy_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        busy & acc & pwrite & hit_ac |=> $stable(ac_ff)) else $error("access taken while busy");
    a_busy_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
        first & ~pwrite & hit_stat |=> prdata_ff[STAT_BUSY] == $past(busy))
        else $error("busy flag misread");

    // Checks, link domain
    a_disabled_pass: assert property (@(posedge transmit_backplane_clock)
        disable iff (!lrst_n_ff) !en_l |=> tx_data_ff == $past(in_ff))
        else $error("disabled slot altered");
    a_loop_prio: assert property (@(posedge transmit_backplane_clock)
        disable iff (!lrst_n_ff) do_lp & ~do_ext |=> tx_data_ff == $past(rx_ff))
        else $error("loopback not applied");
    a_idle_subst: assert property (@(posedge transmit_backplane_clock)
        disable iff (!lrst_n_ff)
        do_idle & ~do_ext & ~do_lp & ~do_gen |=> tx_data_ff == $past(idle_ff[k]))
        else $error("idle byte not sent");
    a_sig_source: assert property (@(posedge transmit_backplane_clock)
        disable iff (!lrst_n_ff) !sig_own |=> tx_sig_out == $past(sig_in_ff))
        else $error("signaling pin not passed");
endmodule : etp_conditioner

// *** hdl/etp_pkg.sv ***
package etp_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [9:0] IDX_CFG  = 10'h060;
    localparam logic [9:0] IDX_STAT = 10'h061;
    localparam logic [9:0] IDX_AC   = 10'h062;
    localparam logic [9:0] IDX_DATA = 10'h063;
    localparam logic [9:0] IDX_OWN  = 10'h06E;
    // Field positions
    localparam int CFG_EN_BIT   = 0;
    localparam int STAT_BUSY    = 7;
    localparam int AC_RW_BIT    = 7;
    localparam int OWN_CAS_BIT  = 0;
    localparam int OWN_DIR_BIT  = 1;
    localparam int CTL_SUBSTITUTE_SELECT     = 7;
    localparam int CTL_DS1      = 5;
    localparam int CTL_DS0      = 4;
    localparam int CTL_TEST     = 3;
    localparam int CTL_LOOP     = 2;
    localparam int SIG_SRC_BIT  = 4;
    // Indirect space
    localparam logic [6:0] IND_CTL_BASE  = 7'h20;
    localparam logic [6:0] IND_SIG_HOLE  = 7'h60;
    localparam int         IND_WORDS     = 96;
    localparam logic [6:0] IND_IDLE_OFS  = 7'h20;
    localparam logic [6:0] IND_SIG_OFS   = 7'h40;
    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_AC   = 8'h00;
    localparam logic       RST_EN   = 1'b0;
    localparam logic [1:0] RST_OWN  = 2'h0;
    // Indirect access time
    localparam int ACC_TIME_NS = 490;
    localparam int PCLK_NS     = 40;
    localparam int ACC_CYC     = (ACC_TIME_NS + PCLK_NS - 1) / PCLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_SYNC = 3'b100
    } etp_state_type;

    // Valid indirect location
    function automatic logic ind_ok(input logic [6:0] a);
        return (a >= IND_CTL_BASE) && (a != IND_SIG_HOLE);
    endfunction : ind_ok

    // Digital milliwatt byte for one of eight samples
    function automatic logic [7:0] mw_byte(input logic alaw, input logic [2:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i[1:0])
            2'h0, 2'h3: b = alaw ? 8'h34 : 8'h1E;
            default:    b = alaw ? 8'h21 : 8'h0B;
        endcase
        return i[2] ? (b | 8'h80) : b;
    endfunction : mw_byte
endpackage : etp_pkg

// *** test/etp_bp_model.sv ***
`timescale 1ns/1ns
module etp_bp_model
(
    // Backplane
    input  wire logic clk,
    output logic      frame,
    output logic      sd,
    output logic      sig,
    output logic      rxp,
    // Generator and detector
    output logic      gen_bit,
    input  wire logic gen_req,
    input  wire logic det_bit,
    input  wire logic det_valid,
    // Conditioned stream
    input  wire logic tx_data,
    input  wire logic tx_sig
);
    logic [7:0] cnt    = 8'h00;
    logic [3:0] gcnt   = 4'h0;
    logic [7:0] cur;
    logic [7:0] lag;
    logic [7:0] got    [32];
    logic [7:0] gsig   [32];
    logic [7:0] det    = 8'h00;
    int         nframe = 0;

    // Payload byte of a slot
    function automatic logic [7:0] din(input logic [4:0] s);
        return 8'hC5 + {3'h0, s};
    endfunction : din

    assign cur     = din(cnt[7:3]);
    assign frame   = (cnt == 8'h00);
    assign sd      = cur[3'h7 - cnt[2:0]];
    assign rxp     = ~sd;
    assign sig     = cnt[3];
    assign gen_bit = gcnt[3];
    assign lag     = cnt - 8'h02;

    // Bit clock and capture of returned bits
    always @(posedge clk)
    begin
        cnt <= cnt + 8'h01;
        gcnt <= (cnt == 8'hFF) ? 4'h0 : gcnt + {3'h0, gen_req};
        got[lag[7:3]][3'h7 - lag[2:0]] <= tx_data;
        gsig[lag[7:3]][3'h7 - lag[2:0]] <= tx_sig;
        if (det_valid)
            det <= {det[6:0], det_bit};
        if (cnt == 8'hFF)
            nframe <= nframe + 1;
    end
endmodule : etp_bp_model

// *** test/e1_transmit_timeslot_conditioner_tb.sv ***
`timescale 1ns/1ns
module e1_transmit_timeslot_conditioner_tb
    import etp_pkg::*;
;
    typedef struct {
        logic [4:0] slot;
        logic [7:0] ctl;
        logic [7:0] idle;
        logic [8:0] e1;
        logic [8:0] e2;
    } etp_row_type;

    localparam int NR = 14;
    // Slot, control, idle, expected enabled, expected with extraction
    etp_row_type rows [NR] = '{
        '{5'h01, 8'h00, 8'h00, 9'h0C6, 9'h0C6}, '{5'h02, 8'h20, 8'h00, 9'h092, 9'h092},
        '{5'h03, 8'h10, 8'h00, 9'h062, 9'h062}, '{5'h04, 8'h30, 8'h00, 9'h036, 9'h036},
        '{5'h05, 8'h80, 8'h5A, 9'h05A, 9'h05A}, '{5'h06, 8'hA0, 8'h3C, 9'h03C, 9'h03C},
        '{5'h07, 8'h90, 8'h00, 9'h101, 9'h101}, '{5'h08, 8'hB0, 8'h00, 9'h100, 9'h100},
        '{5'h0A, 8'h88, 8'h77, 9'h000, 9'h0CF}, '{5'h0B, 8'h38, 8'h00, 9'h0FF, 9'h0D0},
        '{5'h0C, 8'h98, 8'h00, 9'h101, 9'h0D1}, '{5'h0D, 8'h84, 8'h11, 9'h02D, 9'h02D},
        '{5'h0E, 8'h94, 8'h00, 9'h02C, 9'h02C}, '{5'h14, 8'h0C, 8'h00, 9'h026, 9'h0D9}};
    logic [9:0]  ridx [5] = '{IDX_CFG, IDX_STAT, IDX_AC, IDX_DATA, IDX_OWN};

    logic        pclk       = 1'b0;
    logic        lclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        frame;
    logic        sd;
    logic        sig;
    logic        rxp;
    logic        gen_bit;
    logic        gen_req;
    logic        det_bit;
    logic        det_valid;
    logic        tx_data;
    logic        tx_sig;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          n_compared = 0;

    always #20 pclk = ~pclk;
    initial
    begin
        #7;
        forever #15 lclk = ~lclk;
    end

    etp_conditioner i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .transmit_backplane_clock(lclk), .transmit_common_frame_pulse(frame),
        .transmit_serial_data_in(sd), .transmit_signaling_in(sig), .receive_payload_in(rxp),
        .tx_data_out(tx_data), .tx_sig_out(tx_sig), .pattern_gen_bit(gen_bit),
        .pattern_gen_req(gen_req), .pattern_det_bit(det_bit), .pattern_det_valid(det_valid));

    etp_bp_model i_bp (.clk(lclk), .frame(frame), .sd(sd), .sig(sig), .rxp(rxp),
        .gen_bit(gen_bit), .gen_req(gen_req), .det_bit(det_bit), .det_valid(det_valid),
        .tx_data(tx_data), .tx_sig(tx_sig));

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1)
            end_sim();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle_wait;
        int n;
        n = 0;
        apb(1'b0, IDX_STAT, 8'h00);
        chk("busy", 32'h80, rd);
        while (rd[STAT_BUSY] !== 1'b0 && n < 40)
        begin
            apb(1'b0, IDX_STAT, 8'h00);
            n++;
        end
        chk("busy end", 32'h0, rd);
        if (rd !== 32'h0)
            end_sim();
    endtask : idle_wait

    task automatic ind(input logic rw, input logic [6:0] a, input logic [7:0] d);
        if (!rw)
            apb(1'b1, IDX_DATA, d);
        apb(1'b1, IDX_AC, {rw, a});
        idle_wait();
    endtask : ind

    task automatic wait_frames(input int k);
        int t;
        int n;
        t = i_bp.nframe + k;
        n = 0;
        while (i_bp.nframe < t && n < 1000 * k)
        begin
            @(posedge pclk);
            n++;
        end
        chk("frames", t, i_bp.nframe);
        if (i_bp.nframe < t)
            end_sim();
    endtask : wait_frames

    task automatic check_rows(input int ph);
        logic [8:0] e;
        logic [7:0] g;
        for (int i = 0; i < NR; i++)
        begin
            g = i_bp.got[rows[i].slot];
            e = (ph == 1) ? rows[i].e1 : rows[i].e2;
            if (ph == 0)
                e = {1'b0, 8'hC5 + {3'h0, rows[i].slot}};
            if (e[8] && ((g & 8'h7F) == (e[0] ? 8'h34 : 8'h1E)
                || (g & 8'h7F) == (e[0] ? 8'h21 : 8'h0B)))
                e = {1'b0, g};
            chk("slot byte", {24'h0, e[7:0]}, {24'h0, g});
        end
        $display("test phase %0d done", ph);
    endtask : check_rows

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped index
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ridx[i], 8'h00);
            chk("reset value", 32'h0, {31'h0, err} | rd);
        end
        apb(1'b0, 10'h070, 8'h00);
        chk("unmapped", 32'h1, {31'h0, err} | rd);
        $display("test registers done");
        // Slot settings
        for (int i = 0; i < NR; i++)
        begin
            ind(1'b0, IND_CTL_BASE + 7'(rows[i].slot), rows[i].ctl);
            ind(1'b0, 7'h40 + 7'(rows[i].slot), rows[i].idle);
        end
        ind(1'b0, 7'h63, 8'h1A);
        ind(1'b0, 7'h64, 8'h05);
        // Read start, then a start refused while busy
        apb(1'b1, IDX_AC, 8'hC5);
        apb(1'b1, IDX_AC, 8'h21);
        idle_wait();
        apb(1'b0, IDX_AC, 8'h00);
        chk("refused start", 32'hC5, rd);
        apb(1'b0, IDX_DATA, 8'h00);
        chk("idle readback", 32'h5A, rd);
        ind(1'b1, 7'h60, 8'h00);
        apb(1'b0, IDX_DATA, 8'h00);
        chk("hole readback", 32'h0, rd);
        $display("test indirect done");
        // Disabled, enabled, then extraction
        apb(1'b1, IDX_OWN, 8'h01);
        wait_frames(2);
        check_rows(0);
        chk("sig disabled", 32'hFF, {24'h0, i_bp.gsig[3]});
        apb(1'b1, IDX_CFG, 8'h01);
        wait_frames(2);
        check_rows(1);
        chk("sig stored", 32'hFA, {24'h0, i_bp.gsig[3]});
        chk("sig pin", 32'h0, {24'h0, i_bp.gsig[4]});
        apb(1'b1, IDX_OWN, 8'h03);
        wait_frames(2);
        check_rows(2);
        chk("detector", 32'hD9, {24'h0, i_bp.det});
        // Reset in mid-run
        apb(1'b1, IDX_DATA, 8'hA5);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("outputs in reset", 32'h0, {29'h0, tx_data, tx_sig, det_valid});
        presetn <= 1'b1;
        apb(1'b0, IDX_DATA, 8'h00);
        chk("buffer after reset", 32'h0, rd);
        apb(1'b0, IDX_CFG, 8'h00);
        chk("enable after reset", 32'h0, rd);
        $display("test reset done");
        end_sim();
    end
endmodule : e1_transmit_timeslot_conditioner_tb
